// ==== dli_pkg.sv ====
package dli_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [12:0] DLI_CTL_OFS = 13'h0000;
	localparam logic [12:0] DLI_STAT0_OFS = 13'h0004;
	localparam logic [12:0] DLI_STAT1_OFS = 13'h0008;
	localparam logic [12:0] DLI_ADRB_OFS = 13'h000C;
	localparam logic [12:0] DLI_DATB_OFS = 13'h0010;
	localparam logic [12:0] DLI_ADRB_HI_OFS = 13'h0014;
	localparam logic [12:0] DLI_ADRB_LO_OFS = 13'h0018;
	localparam logic [12:0] DLI_DATB_HI_OFS = 13'h001C;
	localparam logic [12:0] DLI_DATB_LO_OFS = 13'h0020;

	// ----------------------------------------
	// Window decode: paddr[12] window, [11] kind, [10] width, [9:2] offset
	// ----------------------------------------
	localparam int DLI_WIN_BIT = 12;
	localparam int DLI_NB_BIT = 11;
	localparam int DLI_W16_BIT = 10;
	localparam int DLI_OFS_LSB = 2;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int DLI_TMO_LSB = 8;
	localparam int DLI_EN_BIT = 16;
	localparam int DLI_ERROR_SUMMARY_FLAG_BIT = 7;
	localparam logic [7:0] DLI_DIV_RST = 8'h0F;
	localparam logic [3:0] DLI_TMO_RST = 4'h0;
	localparam logic [7:0] DLI_CMD_IDLE = 8'h00;
	localparam logic [7:0] DLI_ACK_LINES = 8'hFF;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		DLI_IDLE = 3'b000,
		DLI_CMD = 3'b001,
		DLI_ADR = 3'b011,
		DLI_DAT = 3'b010,
		DLI_ACK = 3'b110
	} dli_state_t;

	typedef struct packed {
		logic idle;
		logic rd;
		logic sz8;
		logic nb;
		logic [7:0] adr;
		logic [15:0] wdata;
	} dli_txn_t;

	typedef struct packed {
		logic [7:0] data;
		logic ack;
		logic err;
		logic [1:0] par;
	} dli_lin_t;

endpackage

// ==== dli_top.sv ====
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Address buffer bit 15 shows direction: 0 write, 1 read.
// - Address buffer bit 14 shows size: 0 sixteen-bit, 1 eight-bit.
// - Bit 12 shows kind, 1 non-blocking; bits 13 and 11:8 read zero.
// - Bits 7:0 hold the window offset; buffer loads at each non-idle transaction start.
// - Data buffer holds write data from start; read data final at acknowledge.
// - Both buffers can also be read one byte at a time.
// - Link comes out of reset disabled; enable is write-once until reset.
// - Any window access while enabled starts a transaction; window picks blocking or not.
// - Link address is the window offset; access width picks 8 or 16 bits.
// - Only one link transaction is ever in progress.
// - Sixteen-bit data is big-endian: high byte at addr, low at addr+1.
// - Blocking write stalls the CPU until the transaction completes.
// - Non-blocking write answers at once; a following window access waits for it.
// - Blocking read stalls until the target returns data, then returns it.
// - Non-blocking window reads return zero.
// - Misaligned 16-bit access becomes two byte transfers, odd address first.
// - Any error sets summary flag, interrupt, freezes buffers, idles transactions.
// - Error before a second queued transfer cancels it and sets cancel flag.
// - No acknowledge within timeout link cycles sets summary and timeout flags.
// - Parity mismatch at acknowledge sets parity flag and stores received bits.
// - Target error seen at acknowledge sets summary and target-error flags.
// - Timeout zero wants acknowledge at once; N allows N wait states.
// - Writing one to summary flag clears all error flags; zero does nothing.
// - Acknowledge with any data line low sets the line-fault flag.
module dli_top
	import dli_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [12:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to target die
	output logic link_clock_out,
	output logic [7:0] link_data_out,
	output logic link_data_oe,
	input wire logic [7:0] link_data_in,
	input wire logic link_ack_in,
	input wire logic link_err_in,
	input wire logic [1:0] link_par_in,
	// Error interrupt, not maskable
	output logic link_error_irq
);

	logic [7:0] div_reg;
	logic [3:0] tmo_reg;
	logic en_reg;
	logic acker_reg, cncl_reg, ack_timeout_flag_reg, terr_reg, parity_fail_flag_reg;
	logic [1:0] rpar_reg;
	logic [15:0] adr_buf_reg, dat_buf_reg;
	dli_state_t state_reg;
	dli_txn_t pend_reg, sec_reg, cur_reg, first_txn, second_txn;
	logic req_reg, split_reg, wait_reg, was_split_reg, bcnt_reg;
	logic [7:0] hi_reg, dcnt_reg;
	logic [3:0] wcnt_reg;
	dli_lin_t s1_reg, s2_reg;
	logic [31:0] reg_rdata;
	logic reg_miss;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic acc, is_win, win_nb, win_w16, mis, reg_wr, stat_clr, busy, start, cancel_now;
	logic [7:0] win_ofs;
	logic tick, link_go, in_ack, to_hit, lk_done, e_time, e_terr, e_par, e_ackl, lk_fail;
	logic final_done;
	logic [1:0] exp_par;
	logic [15:0] rd_word;

	assign acc = psel & penable & ~pready;
	assign is_win = paddr[DLI_WIN_BIT];
	assign win_nb = paddr[DLI_NB_BIT];
	assign win_w16 = paddr[DLI_W16_BIT];
	assign win_ofs = paddr[DLI_OFS_LSB +: 8];
	assign mis = win_w16 & win_ofs[0];
	// Writes land only on the edge where the master sees pready high
	assign reg_wr = psel & penable & pready & pwrite & ~is_win;
	assign stat_clr = reg_wr & (paddr == DLI_STAT0_OFS) & pwdata[DLI_ERROR_SUMMARY_FLAG_BIT];
	assign busy = req_reg | split_reg | (state_reg != DLI_IDLE);
	assign start = acc & is_win & en_reg & ~busy & ~wait_reg;
	assign cancel_now = start & link_error_irq;

	assign tick = en_reg & (dcnt_reg == div_reg) & link_clock_out;
	assign link_go = tick & (state_reg == DLI_IDLE) & req_reg;
	assign in_ack = tick & (state_reg == DLI_ACK);
	// A silent target runs out the wait budget here
	assign to_hit = in_ack & ~s2_reg.ack & (wcnt_reg == tmo_reg);
	assign exp_par = {^dat_buf_reg[15:8], ^dat_buf_reg[7:0]};
	assign e_time = to_hit;
	assign e_terr = in_ack & s2_reg.ack & s2_reg.err;
	assign e_par = in_ack & s2_reg.ack & (s2_reg.par != exp_par);
	assign e_ackl = in_ack & s2_reg.ack & (s2_reg.data != DLI_ACK_LINES);
	assign lk_fail = e_time | e_terr | e_par | e_ackl;
	assign lk_done = (in_ack & (s2_reg.ack | to_hit)) |
		(tick & (state_reg == DLI_CMD) & cur_reg.idle);
	assign final_done = lk_done & (~split_reg | lk_fail);
	assign rd_word = was_split_reg ? {hi_reg, dat_buf_reg[7:0]} : dat_buf_reg;

	// ----------------------------------------
	// Transaction build
	// ----------------------------------------
	always_comb
	begin
		first_txn.idle = link_error_irq;
		first_txn.rd = ~pwrite;
		first_txn.sz8 = ~win_w16 | mis;
		first_txn.nb = win_nb;
		first_txn.adr = win_ofs;
		// High byte goes out first, to the lower address
		if (win_w16 & ~mis)
			first_txn.wdata = pwdata[15:0];
		else if (mis)
			first_txn.wdata = {8'h00, pwdata[15:8]};
		else
			first_txn.wdata = {8'h00, pwdata[7:0]};
		second_txn = first_txn;
		second_txn.idle = 1'b0;
		second_txn.sz8 = 1'b1;
		second_txn.adr = win_ofs + 8'h01;
		second_txn.wdata = {8'h00, pwdata[7:0]};
	end

	always_comb
	begin
		reg_miss = 1'b0;
		case (paddr)
			DLI_CTL_OFS: reg_rdata = {15'h0000, en_reg, 4'h0, tmo_reg, div_reg};
			DLI_STAT0_OFS: reg_rdata = {24'h000000, link_error_irq, acker_reg, cncl_reg,
				ack_timeout_flag_reg, terr_reg, parity_fail_flag_reg, rpar_reg};
			DLI_STAT1_OFS: reg_rdata = {24'h000000, 1'b0, busy, 6'h00};
			DLI_ADRB_OFS: reg_rdata = {16'h0000, adr_buf_reg};
			DLI_DATB_OFS: reg_rdata = {16'h0000, dat_buf_reg};
			DLI_ADRB_HI_OFS: reg_rdata = {24'h000000, adr_buf_reg[15:8]};
			DLI_ADRB_LO_OFS: reg_rdata = {24'h000000, adr_buf_reg[7:0]};
			DLI_DATB_HI_OFS: reg_rdata = {24'h000000, dat_buf_reg[15:8]};
			DLI_DATB_LO_OFS: reg_rdata = {24'h000000, dat_buf_reg[7:0]};
			default:
			begin
				reg_rdata = 32'h00000000;
				reg_miss = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (acc & ~is_win)
			begin
				pready <= 1'b1;
				prdata <= reg_rdata;
				pslverr <= reg_miss;
			end
			else if (acc & ~en_reg)
			begin
				pready <= 1'b1;
				prdata <= 32'h00000000;
				pslverr <= 1'b1;
			end
			else if (acc & wait_reg)
			begin
				// Held low until the link finishes or fails
				if (final_done)
				begin
					pready <= 1'b1;
					prdata <= {16'h0000, rd_word};
					pslverr <= lk_fail;
				end
			end
			else if (start & (link_error_irq | win_nb))
			begin
				pready <= 1'b1;
				prdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Request queue and split handling
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_reg <= 1'b0;
			split_reg <= 1'b0;
			wait_reg <= 1'b0;
			was_split_reg <= 1'b0;
			pend_reg <= '0;
			sec_reg <= '0;
			hi_reg <= 8'h00;
		end
		else
		begin
			if (link_go)
				req_reg <= 1'b0;
			if (start)
			begin
				req_reg <= 1'b1;
				pend_reg <= first_txn;
				sec_reg <= second_txn;
				wait_reg <= ~link_error_irq & ~win_nb;
				split_reg <= ~link_error_irq & mis;
				was_split_reg <= ~link_error_irq & mis;
			end
			if (lk_done & split_reg)
			begin
				split_reg <= 1'b0;
				if (!lk_fail)
				begin
					req_reg <= 1'b1;
					pend_reg <= sec_reg;
					hi_reg <= dat_buf_reg[7:0];
				end
			end
			if (final_done)
				wait_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration, writable only until enable is set
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en_reg <= 1'b0;
			div_reg <= DLI_DIV_RST;
			tmo_reg <= DLI_TMO_RST;
		end
		else if (reg_wr & (paddr == DLI_CTL_OFS) & ~en_reg)
		begin
			en_reg <= pwdata[DLI_EN_BIT];
			div_reg <= pwdata[7:0];
			tmo_reg <= pwdata[DLI_TMO_LSB +: 4];
		end
	end

	// ----------------------------------------
	// Link clock divider
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dcnt_reg <= 8'h00;
			link_clock_out <= 1'b0;
		end
		else if (!en_reg)
		begin
			dcnt_reg <= 8'h00;
			link_clock_out <= 1'b0;
		end
		else if (dcnt_reg == div_reg)
		begin
			dcnt_reg <= 8'h00;
			link_clock_out <= ~link_clock_out;
		end
		else
			dcnt_reg <= dcnt_reg + 8'h01;
	end

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
		end
		else
		begin
			s1_reg <= {link_data_in, link_ack_in, link_err_in, link_par_in};
			s2_reg <= s1_reg;
		end
	end

	// ----------------------------------------
	// Link sequencer, steps on falling link clock
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= DLI_IDLE;
			link_data_out <= 8'h00;
			link_data_oe <= 1'b0;
			adr_buf_reg <= 16'h0000;
			dat_buf_reg <= 16'h0000;
			cur_reg <= '0;
			bcnt_reg <= 1'b0;
			wcnt_reg <= 4'h0;
		end
		else if (tick)
		begin
			case (state_reg)
				DLI_IDLE:
				begin
					if (req_reg)
					begin
						cur_reg <= pend_reg;
						link_data_oe <= 1'b1;
						state_reg <= DLI_CMD;
						if (pend_reg.idle)
							link_data_out <= DLI_CMD_IDLE;
						else
						begin
							link_data_out <= {1'b1, pend_reg.rd, pend_reg.sz8, pend_reg.nb, 4'h0};
							// Idle commands leave the buffers frozen
							adr_buf_reg <= {pend_reg.rd, pend_reg.sz8, 1'b0, pend_reg.nb,
								4'h0, pend_reg.adr};
							dat_buf_reg <= pend_reg.rd ? 16'h0000 : pend_reg.wdata;
						end
					end
				end
				DLI_CMD:
				begin
					if (cur_reg.idle)
					begin
						link_data_oe <= 1'b0;
						state_reg <= DLI_IDLE;
					end
					else
					begin
						link_data_out <= cur_reg.adr;
						state_reg <= DLI_ADR;
					end
				end
				DLI_ADR:
				begin
					bcnt_reg <= ~cur_reg.sz8;
					state_reg <= DLI_DAT;
					if (cur_reg.rd)
						link_data_oe <= 1'b0;
					else
						link_data_out <= cur_reg.sz8 ? dat_buf_reg[7:0] : dat_buf_reg[15:8];
				end
				DLI_DAT:
				begin
					if (cur_reg.rd)
						dat_buf_reg <= {dat_buf_reg[7:0], s2_reg.data};
					if (bcnt_reg)
					begin
						bcnt_reg <= 1'b0;
						if (!cur_reg.rd)
							link_data_out <= dat_buf_reg[7:0];
					end
					else
					begin
						link_data_oe <= 1'b0;
						wcnt_reg <= 4'h0;
						state_reg <= DLI_ACK;
					end
				end
				DLI_ACK:
				begin
					if (s2_reg.ack | to_hit)
						state_reg <= DLI_IDLE;
					else
						wcnt_reg <= wcnt_reg + 4'h1;
				end
				default:
				begin
					state_reg <= DLI_IDLE;
					link_data_oe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Error flags; a new error beats a clear in the same cycle
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			link_error_irq <= 1'b0;
			acker_reg <= 1'b0;
			cncl_reg <= 1'b0;
			ack_timeout_flag_reg <= 1'b0;
			terr_reg <= 1'b0;
			parity_fail_flag_reg <= 1'b0;
			rpar_reg <= 2'b00;
		end
		else
		begin
			if (stat_clr)
			begin
				link_error_irq <= 1'b0;
				acker_reg <= 1'b0;
				cncl_reg <= 1'b0;
				ack_timeout_flag_reg <= 1'b0;
				terr_reg <= 1'b0;
				parity_fail_flag_reg <= 1'b0;
			end
			if (lk_fail)
				link_error_irq <= 1'b1;
			if (e_time)
				ack_timeout_flag_reg <= 1'b1;
			if (e_terr)
				terr_reg <= 1'b1;
			if (e_ackl)
				acker_reg <= 1'b1;
			if (e_par)
			begin
				parity_fail_flag_reg <= 1'b1;
				rpar_reg <= s2_reg.par;
			end
			if (cancel_now | (lk_done & lk_fail & split_reg))
				cncl_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_enable_sticky: assert property (en_reg |=> en_reg)
		else $error("enable dropped");
	chk_dir_bit: assert property (link_go && !pend_reg.idle |=>
		adr_buf_reg[15] == $past(pend_reg.rd) && state_reg == DLI_CMD)
		else $error("direction bit wrong");
	chk_size_bit: assert property (link_go && !pend_reg.idle |=>
		adr_buf_reg[14] == $past(pend_reg.sz8))
		else $error("size bit wrong");
	chk_kind_bits: assert property (link_go && !pend_reg.idle |=>
		adr_buf_reg[12] == $past(pend_reg.nb) && !adr_buf_reg[13] && adr_buf_reg[11:8] == 4'h0)
		else $error("kind or reserved bits wrong");
	chk_adr_bits: assert property (link_go && !pend_reg.idle |=>
		adr_buf_reg[7:0] == $past(pend_reg.adr))
		else $error("buffer address wrong");
	chk_wdata_buf: assert property (link_go && !pend_reg.idle && !pend_reg.rd |=>
		dat_buf_reg == $past(pend_reg.wdata))
		else $error("write data not buffered");
	chk_one_txn: assert property ((state_reg != DLI_IDLE) |-> !link_go)
		else $error("second transaction launched");
	chk_blk_stall: assert property (acc && wait_reg && !final_done |=> !pready)
		else $error("blocking access answered early");
	chk_nb_read_zero: assert property (start && win_nb && !pwrite |=>
		pready && prdata == 32'h00000000)
		else $error("non-blocking read not zero");
	chk_split_second: assert property (lk_done && split_reg && !lk_fail |=>
		req_reg && pend_reg.adr == $past(cur_reg.adr) + 8'h01)
		else $error("second byte not queued");
	chk_err_freeze: assert property (link_error_irq && !stat_clr |=>
		$stable(adr_buf_reg) && $stable(dat_buf_reg))
		else $error("buffers changed under error");
	chk_timeout_flag: assert property (e_time |=> ack_timeout_flag_reg && link_error_irq)
		else $error("timeout not flagged");
	chk_parity_store: assert property (e_par |=> parity_fail_flag_reg && rpar_reg == $past(s2_reg.par))
		else $error("parity not stored");
	chk_err_clear: assert property (stat_clr && !lk_fail && !cancel_now |=>
		!link_error_irq && !ack_timeout_flag_reg && !parity_fail_flag_reg && !acker_reg && !cncl_reg)
		else $error("flags not cleared");
	chk_idle_answer: assert property (cancel_now |=> pready && cncl_reg &&
		prdata == 32'h00000000)
		else $error("idle access not answered");

	cov_blk_done: cover property (acc && wait_reg && final_done && !lk_fail);
	cov_timeout: cover property (e_time);
	cov_cancel: cover property (cancel_now);
	cov_split: cover property (lk_done && split_reg && !lk_fail);

endmodule

// ==== dli_tgt_model.sv ====
`timescale 1ns/1ps
module dli_tgt_model
	import dli_pkg::*;
(
	// Link
	input wire logic lclk,
	input wire logic [7:0] dout,
	input wire logic oe,
	output logic [7:0] din,
	output logic ack,
	output logic err,
	output logic [1:0] par,
	// Faults: 1 parity, 2 error, 3 line low, 4 no ack
	input wire logic [3:0] wait_n,
	input wire logic [2:0] flt
);
	logic [7:0] mem [256];
	logic [7:0] cmd, adr, b0, b1, v;
	int step;
	int nb;
	initial
	begin
		step = 0;
		din = 8'h5A;
		ack = 1'b0;
		err = 1'b0;
		par = 2'h0;
		cmd = 8'h00;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end
	always @(posedge lclk)
	begin
		nb = cmd[5] ? 1 : 2;
		ack <= 1'b0;
		err <= 1'b0;
		// Released lines toggle so stale data never looks valid
		din <= ~din;
		if (step == 0)
		begin
			if (oe && dout[7])
			begin
				cmd <= dout;
				step <= 1;
			end
		end
		else if (step == 1)
		begin
			adr <= dout;
			step <= 2;
		end
		else if (step < 2 + nb)
		begin
			v = cmd[6] ? mem[8'(adr + step - 2)] : dout;
			if (cmd[6])
				din <= v;
			else
				mem[8'(adr + step - 2)] <= v;
			if (step == 2)
				b0 <= v;
			b1 <= v;
			step <= step + 1;
		end
		// A wait count lowered during a late acknowledge must not strand the step counter
		else if (step >= 2 + nb + int'(wait_n))
		begin
			step <= 0;
			if (flt != 3'h4)
			begin
				ack <= 1'b1;
				err <= (flt == 3'h2);
				din <= (flt == 3'h3) ? 8'hF7 : 8'hFF;
				par <= (cmd[5] ? {1'b0, ^b1} : {^b0, ^b1}) ^ {2{flt == 3'h1}};
			end
		end
		else
			step <= step + 1;
	end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
	import dli_pkg::*;
;
	logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic lclk, loe, lack, lerr, rerr;
	logic [7:0] ldo, ldi, tdin, pre;
	logic [1:0] lpar;
	logic [3:0] wait_n;
	logic [2:0] flt;
	int errors, n_checks, lat;

	dli_top u_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clock_out(lclk), .link_data_out(ldo), .link_data_oe(loe),
		.link_data_in(ldi), .link_ack_in(lack), .link_err_in(lerr), .link_par_in(lpar),
		.link_error_irq(irq));
	dli_tgt_model u_tgt (.lclk(lclk), .dout(ldo), .oe(loe), .din(tdin), .ack(lack),
		.err(lerr), .par(lpar), .wait_n(wait_n), .flt(flt));
	assign ldi = loe ? ldo : tdin;

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [12:0] win(input logic [1:0] k, input logic [7:0] ofs);
		return {1'b1, k, ofs, 2'b00};
	endfunction

	task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		lat = 0;
		do
		begin
			@(posedge mclk);
			lat++;
		end
		while (pready !== 1'b1 && lat < 20000);
		if (lat >= 20000)
		begin
			errors++;
			tally_and_finish();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_enable();
		apb(0, 13'h0000, 0);
		chk(rdat, 32'h0000000F);
		apb(1, win(2'b00, 8'h01), 32'h12);
		chk(rerr, 1);
		apb(1, 13'h0000, 32'h0001020F);
		apb(1, 13'h0000, 32'h00000000);
		apb(0, 13'h0000, 0);
		chk(rdat, 32'h0001020F);
	endtask

	task automatic t_blk_write();
		wait_n <= 4'h2;
		apb(1, win(2'b00, 8'h10), 32'h3C);
		chk({rerr, lat > 64}, 2'b01);
		chk(u_tgt.mem[8'h10], 8'h3C);
		apb(0, 13'h000C, 0);
		chk(rdat, 32'h4010);
		apb(0, 13'h0020, 0);
		chk(rdat[7:0], 8'h3C);
		wait_n <= 4'h0;
	endtask

	task automatic t_blk_read();
		apb(0, win(2'b01, 8'h20), 0);
		chk(rdat[15:0], {8'h20 ^ 8'hA5, 8'h21 ^ 8'hA5});
		apb(0, 13'h000C, 0);
		chk(rdat, 32'h8020);
		apb(0, 13'h0014, 0);
		chk(rdat[7:0], 8'h80);
		apb(0, 13'h0010, 0);
		chk(rdat[15:0], {8'h20 ^ 8'hA5, 8'h21 ^ 8'hA5});
	endtask

	task automatic t_split();
		apb(1, win(2'b01, 8'h31), 32'hBEEF);
		chk({u_tgt.mem[8'h31], u_tgt.mem[8'h32]}, 16'hBEEF);
		apb(0, 13'h000C, 0);
		chk(rdat, 32'h4032);
	endtask

	task automatic t_nonblock();
		apb(1, win(2'b10, 8'h40), 32'h11);
		chk(lat < 4, 1);
		apb(0, 13'h0008, 0);
		chk(rdat[6], 1);
		// The buffer loads when the command byte goes out, up to a link period later
		repeat (40) @(posedge mclk);
		apb(0, 13'h000C, 0);
		chk(rdat, 32'h5040);
		apb(1, win(2'b00, 8'h41), 32'h22);
		chk({u_tgt.mem[8'h40], u_tgt.mem[8'h41]}, 16'h1122);
		apb(0, win(2'b11, 8'h50), 0);
		chk(rdat, 32'h00000000);
		chk(lat < 4, 1);
	endtask

	task automatic t_errors();
		logic [2:0] fl [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
		logic [3:0] wn [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3};
		logic [7:0] ex [5] = '{8'h86, 8'h88, 8'hC0, 8'h90, 8'h90};
		logic [7:0] mk [5] = '{8'hFF, 8'hFC, 8'hFC, 8'hFC, 8'hFC};
		for (int i = 0; i < 5; i++)
		begin
			// Earlier link traffic must be over before the fault is armed
			repeat (400) @(posedge mclk);
			flt <= fl[i];
			wait_n <= wn[i];
			pre = u_tgt.mem[8'h70];
			apb(1, win(2'b00, 8'h60), 32'h5B);
			chk(rerr, 1);
			apb(0, 13'h0004, 0);
			chk(rdat[7:0] & mk[i], ex[i]);
			chk(irq, 1);
			flt <= 3'h0;
			wait_n <= 4'h0;
			apb(1, win(2'b00, 8'h70), 32'h99);
			chk({lat < 8, u_tgt.mem[8'h70]}, {1'b1, pre});
			apb(0, 13'h000C, 0);
			chk(rdat, 32'h4060);
			apb(0, 13'h0004, 0);
			chk(rdat[5], 1);
			apb(1, 13'h0004, 32'h0);
			chk(irq, 1);
			apb(1, 13'h0004, 32'h80);
			apb(0, 13'h0004, 0);
			chk({irq, rdat[7:2]}, 7'h0);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		errors = 0;
		n_checks = 0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 13'h0000;
		pwdata = 32'h0;
		wait_n = 4'h0;
		flt = 3'h0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		t_enable();
		t_blk_write();
		t_blk_read();
		t_split();
		t_nonblock();
		t_errors();
		tally_and_finish();
	end
endmodule
